// [design/psil_top.sv]
// Primary status and interrupt logic: status collection, register port,
// enable register and interrupt request.
// Assumes all status sources run on i_clk and give one-cycle pulses for
// events and steady levels for busy indications.
`timescale 1ns/1ps
`default_nettype none
`include "psil_cfg.svh"
module psil_top (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Register port
  input  wire psil_pkg::psil_addr_t i_addr,
  input  wire psil_pkg::psil_word_t i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output var psil_pkg::psil_word_t o_rdata,
  output logic                    o_irq,
  // Bus interface events
  input  wire logic               i_bus_parity_err,
  input  wire logic               i_bus_abort_err,
  input  wire logic               i_realtime_parity_err,
  input  wire logic               i_vsync,
  input  wire logic               i_seq_wait,
  input  wire logic               i_seq_in_control,
  // Register sequencer, index 1 is task 1
  input  wire logic [1:0]         i_seq_task_start,
  input  wire logic [1:0]         i_seq_irq,
  input  wire logic [1:0]         i_seq_tardy,
  input  wire logic [1:0]         i_seq_wait_expired,
  input  wire logic [1:0]         i_seq_reg_err,
  input  wire logic [1:0]         i_seq_page_err,
  input  wire logic [1:0]         i_seq_active,
  input  wire logic               i_shadow_load_active,
  // External data port
  input  wire logic               i_ext_port_busy,
  input  wire logic               i_ext_cmd_start,
  input  wire logic               i_ext_port_format_err,
  input  wire logic               i_ext_port_timeout,
  // Two-wire master
  input  wire logic               i_twowire_busy,
  input  wire logic               i_twowire_start,
  input  wire logic               i_twowire_addr_err,
  input  wire logic               i_twowire_write_err,
  // Audio: index 0 out1, 1 in1, 2 out2, 3 in2
  input  wire logic [3:0]         i_audio_guard,
  input  wire logic [3:0]         i_audio_start,
  input  wire logic [3:0]         i_audio_fifo_flow_err,
  // Video channels 1 to 3
  input  wire logic [2:0]         i_video_addr_guard_err,
  input  wire logic [2:0]         i_video_fifo_flow_err
);
  import psil_pkg::*;

  psil_top_s st;
  psil_top_s next_st;
  psil_sel_e sel;
  psil_word_t w1c;
  psil_word_t trig;
  logic [`PSIL_STK_W-1:0] stk_set;
  logic [`PSIL_STK_W-1:0] stk_clr;
  logic [`PSIL_STK_W-1:0] stk_q;
  logic [1:0] fault;
  logic [1:0] reg_err;
  logic [1:0] page_err;

  psil_irq_if irq_ifc ();

  // Address decode
  always_comb begin
    if (i_addr == `PSIL_OFF_IER) begin
      sel = PSIL_SEL_IER;
    end else if (i_addr == `PSIL_OFF_ISR) begin
      sel = PSIL_SEL_ISR;
    end else if (i_addr == `PSIL_OFF_PSR) begin
      sel = PSIL_SEL_PSR;
    end else if (i_addr == `PSIL_OFF_SSR) begin
      sel = PSIL_SEL_SSR;
    end else begin
      sel = PSIL_SEL_NONE;
    end
  end

  // Write-one effects on flags and primary status
  always_comb begin
    w1c  = '0;
    trig = '0;
    if (i_wr && (sel == PSIL_SEL_ISR)) begin
      w1c = i_wdata;
    end
    if (i_wr && (sel == PSIL_SEL_PSR)) begin
      trig = i_wdata;
    end
  end

  // Sticky status sources
  always_comb begin
    stk_set = '0;
    stk_clr = '0;
    stk_set[`PSIL_S_BPAR] = i_bus_parity_err;
    stk_clr[`PSIL_S_BPAR] = w1c[`PSIL_P_BPAR];
    stk_set[`PSIL_S_ABORT] = i_bus_abort_err;
    stk_clr[`PSIL_S_ABORT] = w1c[`PSIL_P_ABORT];
    // Window closes at vertical sync, or at a wait under sequencer control
    stk_set[`PSIL_S_RTPAR] = i_realtime_parity_err;
    stk_clr[`PSIL_S_RTPAR] = i_seq_in_control ? i_seq_wait : i_vsync;
    stk_set[`PSIL_S_SEQIRQ +: 2] = i_seq_irq;
    stk_clr[`PSIL_S_SEQIRQ +: 2] = i_seq_task_start;
    stk_set[`PSIL_S_TARDY +: 2] = i_seq_tardy;
    stk_clr[`PSIL_S_TARDY +: 2] = i_seq_task_start;
    stk_set[`PSIL_S_EXPIRE +: 2] = i_seq_wait_expired;
    stk_clr[`PSIL_S_EXPIRE +: 2] = i_seq_task_start;
    stk_set[`PSIL_S_REGERR +: 2] = i_seq_reg_err;
    stk_clr[`PSIL_S_REGERR +: 2] = i_seq_task_start | w1c[`PSIL_P_FAULT +: 2];
    stk_set[`PSIL_S_PGERR +: 2] = i_seq_page_err;
    stk_clr[`PSIL_S_PGERR +: 2] = i_seq_task_start | w1c[`PSIL_P_FAULT +: 2];
    stk_set[`PSIL_S_EXTFMT] = i_ext_port_format_err;
    stk_clr[`PSIL_S_EXTFMT] = i_ext_cmd_start | w1c[`PSIL_P_EXTEVT];
    stk_set[`PSIL_S_EXTTO] = i_ext_port_timeout;
    stk_clr[`PSIL_S_EXTTO] = i_ext_cmd_start | w1c[`PSIL_P_EXTEVT];
    stk_set[`PSIL_S_TWADDR] = i_twowire_addr_err;
    stk_clr[`PSIL_S_TWADDR] = i_twowire_start | w1c[`PSIL_P_TWERR];
    stk_set[`PSIL_S_TWWR] = i_twowire_write_err;
    stk_clr[`PSIL_S_TWWR] = i_twowire_start | w1c[`PSIL_P_TWERR];
    stk_set[`PSIL_S_AUDIO +: 4] = i_audio_guard;
    stk_clr[`PSIL_S_AUDIO +: 4] = i_audio_start;
  end

  psil_sticky u_sticky (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_set (stk_set),
    .i_clr (stk_clr),
    .o_q   (stk_q)
  );

  assign reg_err  = stk_q[`PSIL_S_REGERR +: 2];
  assign page_err = stk_q[`PSIL_S_PGERR +: 2];
  assign fault    = reg_err | page_err;

  // Next state: enable, status summaries, read data, request
  always_comb begin
    next_st = st;
    if (i_wr && (sel == PSIL_SEL_IER)) begin
      next_st.interrupt_enable_reg = i_wdata & `PSIL_IMPL_MASK;
    end

    // Primary status, summarised from sources and secondary flags
    next_st.primary_status = '0;
    next_st.primary_status[`PSIL_P_BPAR] = stk_q[`PSIL_S_BPAR];
    next_st.primary_status[`PSIL_P_ABORT] = stk_q[`PSIL_S_ABORT];
    next_st.primary_status[`PSIL_P_RTPAR] = stk_q[`PSIL_S_RTPAR];
    next_st.primary_status[`PSIL_P_SEQIRQ +: 2] = stk_q[`PSIL_S_SEQIRQ +: 2];
    next_st.primary_status[`PSIL_P_TARDY +: 2] = stk_q[`PSIL_S_TARDY +: 2];
    next_st.primary_status[`PSIL_P_FAULT +: 2] = fault;
    next_st.primary_status[`PSIL_P_EXPIRE +: 2] = stk_q[`PSIL_S_EXPIRE +: 2];
    next_st.primary_status[`PSIL_P_SHADOW] = i_shadow_load_active;
    next_st.primary_status[`PSIL_P_EXTBUSY] = i_ext_port_busy;
    next_st.primary_status[`PSIL_P_EXTEVT] = stk_q[`PSIL_S_EXTFMT] | stk_q[`PSIL_S_EXTTO];
    next_st.primary_status[`PSIL_P_TWBUSY] = i_twowire_busy;
    next_st.primary_status[`PSIL_P_TWERR] = stk_q[`PSIL_S_TWADDR] | stk_q[`PSIL_S_TWWR];
    next_st.primary_status[`PSIL_P_AUDIO +: 4] = stk_q[`PSIL_S_AUDIO +: 4];
    next_st.primary_status[`PSIL_P_AFIFO] = |i_audio_fifo_flow_err;
    next_st.primary_status[`PSIL_P_VGUARD] = |i_video_addr_guard_err;
    next_st.primary_status[`PSIL_P_VFIFO] = |i_video_fifo_flow_err;

    // Secondary status detail
    next_st.secondary_status = '0;
    next_st.secondary_status[`PSIL_Q_T1RE] = reg_err[1];
    next_st.secondary_status[`PSIL_Q_T1PE] = page_err[1];
    next_st.secondary_status[`PSIL_Q_T1ACT] = i_seq_active[1];
    next_st.secondary_status[`PSIL_Q_T0RE] = reg_err[0];
    next_st.secondary_status[`PSIL_Q_T0PE] = page_err[0];
    next_st.secondary_status[`PSIL_Q_T0ACT] = i_seq_active[0];
    next_st.secondary_status[`PSIL_Q_EXTTO] = stk_q[`PSIL_S_EXTTO];
    next_st.secondary_status[`PSIL_Q_EXTFMT] = stk_q[`PSIL_S_EXTFMT];
    next_st.secondary_status[`PSIL_Q_TWADDR] = stk_q[`PSIL_S_TWADDR];
    next_st.secondary_status[`PSIL_Q_TWWR] = stk_q[`PSIL_S_TWWR];

    // Read data valid only in the cycle after the strobe
    next_st.rdata = '0;
    if (i_rd) begin
      if (sel == PSIL_SEL_IER) begin
        next_st.rdata = st.interrupt_enable_reg;
      end else if (sel == PSIL_SEL_ISR) begin
        next_st.rdata = irq_ifc.flags;
      end else if (sel == PSIL_SEL_PSR) begin
        next_st.rdata = st.primary_status;
      end else if (sel == PSIL_SEL_SSR) begin
        next_st.rdata = st.secondary_status;
      end else begin
        next_st.rdata = '0;
      end
    end

    next_st.irq = |(irq_ifc.flags & st.interrupt_enable_reg);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.interrupt_enable_reg   <= '0;
      st.primary_status   <= `PSIL_PSR_RST;
      st.secondary_status   <= `PSIL_SSR_RST;
      st.rdata <= '0;
      st.irq   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Flag module sees registered status, enable and write effects
  assign irq_ifc.status = st.primary_status;
  assign irq_ifc.enable = st.interrupt_enable_reg;
  assign irq_ifc.trig   = trig;
  assign irq_ifc.clr    = w1c;

  psil_flag u_flag (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .ifc   (irq_ifc.flag)
  );

  assign o_rdata = st.rdata;
  assign o_irq   = st.irq;
endmodule
`default_nettype wire

// [design/psil_cfg.svh]
// Constants for the primary status and interrupt logic.
// Assumes byte addresses on a 12-bit register port.
`ifndef PSIL_CFG_SVH
`define PSIL_CFG_SVH
// Register byte offsets
`define PSIL_OFF_IER 12'h0dc
`define PSIL_OFF_ISR 12'h10c
`define PSIL_OFF_PSR 12'h110
`define PSIL_OFF_SSR 12'h114
// Primary status bit positions (pairs and groups are base indices)
`define PSIL_P_BPAR 31
`define PSIL_P_ABORT 30
`define PSIL_P_RTPAR 29
`define PSIL_P_SEQIRQ 27
`define PSIL_P_TARDY 25
`define PSIL_P_FAULT 23
`define PSIL_P_EXPIRE 21
`define PSIL_P_SHADOW 20
`define PSIL_P_EXTBUSY 19
`define PSIL_P_EXTEVT 18
`define PSIL_P_TWBUSY 17
`define PSIL_P_TWERR 16
`define PSIL_P_AUDIO 12
`define PSIL_P_AFIFO 11
`define PSIL_P_VGUARD 10
`define PSIL_P_VFIFO 9
// Secondary status bit positions
`define PSIL_Q_T1RE 29
`define PSIL_Q_T1PE 28
`define PSIL_Q_T1ACT 27
`define PSIL_Q_T0RE 26
`define PSIL_Q_T0PE 25
`define PSIL_Q_T0ACT 24
`define PSIL_Q_EXTTO 23
`define PSIL_Q_EXTFMT 22
`define PSIL_Q_TWADDR 21
`define PSIL_Q_TWWR 20
// Sticky source vector layout
`define PSIL_STK_W 21
`define PSIL_S_BPAR 0
`define PSIL_S_ABORT 1
`define PSIL_S_RTPAR 2
`define PSIL_S_SEQIRQ 3
`define PSIL_S_TARDY 5
`define PSIL_S_EXPIRE 7
`define PSIL_S_REGERR 9
`define PSIL_S_PGERR 11
`define PSIL_S_EXTFMT 13
`define PSIL_S_EXTTO 14
`define PSIL_S_TWADDR 15
`define PSIL_S_TWWR 16
`define PSIL_S_AUDIO 17
// Reset values and masks
`define PSIL_STK_RST 21'h004000
`define PSIL_PSR_RST 32'h00040000
`define PSIL_SSR_RST 32'h00800000
`define PSIL_FALL_MASK 32'h001a0000
`define PSIL_IMPL_MASK 32'hfffffe00
`endif

// [design/psil_pkg.sv]
// Types for the primary status and interrupt logic.
// Assumes psil_cfg.svh is on the include path.
`include "psil_cfg.svh"
package psil_pkg;
  typedef logic [31:0] psil_word_t;
  typedef logic [11:0] psil_addr_t;
  typedef enum logic [2:0] {PSIL_SEL_NONE, PSIL_SEL_IER, PSIL_SEL_ISR, PSIL_SEL_PSR, PSIL_SEL_SSR} psil_sel_e;
  typedef struct packed {
    psil_word_t interrupt_enable_reg;
    psil_word_t primary_status;
    psil_word_t secondary_status;
    psil_word_t rdata;
    logic       irq;
  } psil_top_s;
  typedef struct packed {
    psil_word_t prev;
    psil_word_t flags;
  } psil_flag_s;
  typedef struct packed {
    logic [`PSIL_STK_W-1:0] q;
  } psil_stk_s;
endpackage

// [design/psil_irq_if.sv]
// Carrier between the status collector and the interrupt flag module.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface psil_irq_if;
  logic [31:0] status;
  logic [31:0] enable;
  logic [31:0] trig;
  logic [31:0] clr;
  logic [31:0] flags;
  modport ctl  (output status, output enable, output trig, output clr, input flags);
  modport flag (input status, input enable, input trig, input clr, output flags);
endinterface
`default_nettype wire

// [design/psil_sticky.sv]
// Vector of sticky status bits, set and clear per bit.
// Assumes single-cycle set and clear pulses from the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "psil_cfg.svh"
module psil_sticky (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic [`PSIL_STK_W-1:0] i_set,
  input  wire logic [`PSIL_STK_W-1:0] i_clr,
  output logic      [`PSIL_STK_W-1:0] o_q
);
  import psil_pkg::*;
  psil_stk_s st;
  psil_stk_s next_st;
  // Set wins over a clear in the same cycle
  always_comb begin
    next_st.q = (st.q & ~i_clr) | i_set;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.q <= `PSIL_STK_RST;
    end else begin
      st <= next_st;
    end
  end
  assign o_q = st.q;
endmodule
`default_nettype wire

// [design/psil_flag.sv]
// Interrupt flag register with per-bit edge selection.
// Assumes status and enable arrive registered, trigger and clear as
// same-clock pulses from the register port.
`timescale 1ns/1ps
`default_nettype none
`include "psil_cfg.svh"
module psil_flag (
  input wire logic i_clk,
  input wire logic i_rst,
  psil_irq_if.flag ifc
);
  import psil_pkg::*;
  localparam psil_word_t FALL = `PSIL_FALL_MASK;
  localparam psil_word_t IMPL = `PSIL_IMPL_MASK;
  psil_flag_s st;
  psil_flag_s next_st;
  psil_word_t edge_hit;
  always_comb begin
    edge_hit = (FALL & st.prev & ~ifc.status) | (~FALL & ~st.prev & ifc.status);
    next_st = st;
    next_st.prev = ifc.status;
    // Enabled edge or software trigger sets, set beats clear
    next_st.flags = ((st.flags & ~ifc.clr) | ((edge_hit | ifc.trig) & ifc.enable)) & IMPL;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.prev  <= `PSIL_PSR_RST;
      st.flags <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign ifc.flags = st.flags;
endmodule
`default_nettype wire

// [bench/psil_assertions.sv]
// Checker for the psil_top register port and interrupt output.
// Assumes psil_cfg.svh on the include path; bound into psil_top.
`timescale 1ns/1ps
`default_nettype none
`include "psil_cfg.svh"
module psil_assertions (
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire psil_pkg::psil_addr_t i_addr,
  input wire logic                i_wr,
  input wire logic                i_rd,
  input wire psil_pkg::psil_word_t o_rdata,
  input wire logic                o_irq,
  input wire logic                i_bus_parity_err,
  input wire logic [1:0]          i_seq_reg_err,
  input wire logic [1:0]          i_seq_task_start,
  input wire logic                i_shadow_load_active,
  input wire logic                i_ext_port_busy,
  input wire logic                i_twowire_busy,
  input wire logic [3:0]          i_audio_fifo_flow_err,
  input wire logic [2:0]          i_video_addr_guard_err,
  input wire logic [2:0]          i_video_fifo_flow_err
);
  import psil_pkg::*;
  // Live OR sources and busy levels as seen by the primary word
  wire logic [2:0] live_or = {|i_audio_fifo_flow_err, |i_video_addr_guard_err, |i_video_fifo_flow_err};
  wire logic [2:0] busy    = {i_shadow_load_active, i_ext_port_busy, i_twowire_busy};
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (i_rd && !(i_addr inside {`PSIL_OFF_IER, `PSIL_OFF_ISR, `PSIL_OFF_PSR,
    `PSIL_OFF_SSR}) |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  a_low_bits: assert property (i_rd && i_addr inside {`PSIL_OFF_IER, `PSIL_OFF_ISR, `PSIL_OFF_PSR}
    |=> o_rdata[8:0] == 9'h0) else $error("unimplemented low bits set");
  a_live_or: assert property (i_rd && i_addr == `PSIL_OFF_PSR |=> o_rdata[11:9] == $past(live_or, 2))
    else $error("fifo or guard summary wrong");
  a_busy_mirror: assert property (i_rd && i_addr == `PSIL_OFF_PSR
    |=> {o_rdata[20:19], o_rdata[17]} == $past(busy, 2)) else $error("busy bits wrong");
  a_sec_top: assert property (i_rd && i_addr == `PSIL_OFF_SSR |=> o_rdata[31:30] == 2'h0)
    else $error("secondary top bits set");
  a_irq_flag: assert property (i_rd && i_addr == `PSIL_OFF_ISR |=> !o_irq || o_rdata != 32'h0)
    else $error("request without a flag");
  a_parity_set: assert property (i_bus_parity_err ##1 !i_wr ##1 (i_rd && i_addr == `PSIL_OFF_PSR)
    |=> o_rdata[31]) else $error("parity status not set");
  a_fault_set: assert property (i_seq_reg_err[1] ##1 !(i_wr || i_seq_task_start[1])
    ##1 (i_rd && i_addr == `PSIL_OFF_PSR) |=> o_rdata[24]) else $error("task fault status not set");
endmodule
bind psil_top psil_assertions u_chk (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .o_rdata, .o_irq, .i_bus_parity_err,
  .i_seq_reg_err, .i_seq_task_start, .i_shadow_load_active, .i_ext_port_busy, .i_twowire_busy,
  .i_audio_fifo_flow_err, .i_video_addr_guard_err, .i_video_fifo_flow_err);
`default_nettype wire

// [bench/psil_top_test.sv]
// Self-checking bench for psil_top through its register port.
// Assumes design and checker files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
`include "psil_cfg.svh"
module psil_top_test;
  import psil_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  psil_addr_t  i_addr = 12'h0;
  psil_word_t  i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_seq_wait = 1'b0;
  logic        i_seq_in_control = 1'b0;
  psil_word_t  o_rdata;
  logic        o_irq;
  logic [20:0] ev = '0;
  logic [8:0]  cl = '0;
  logic [14:0] lv = '0;
  int          fails = 0;
  int          samples_checked = 0;
  wire logic i_bus_parity_err, i_bus_abort_err, i_realtime_parity_err, i_ext_port_format_err, i_ext_port_timeout,
    i_twowire_addr_err, i_twowire_write_err, i_vsync, i_ext_cmd_start, i_twowire_start, i_shadow_load_active,
    i_ext_port_busy, i_twowire_busy;
  wire logic [1:0] i_seq_irq, i_seq_tardy, i_seq_wait_expired, i_seq_reg_err, i_seq_page_err, i_seq_task_start,
    i_seq_active;
  wire logic [3:0] i_audio_guard, i_audio_start, i_audio_fifo_flow_err;
  wire logic [2:0] i_video_addr_guard_err, i_video_fifo_flow_err;
  // Event pulses, clear pulses and level sources as packed vectors
  assign {i_audio_guard, i_twowire_write_err, i_twowire_addr_err, i_ext_port_timeout, i_ext_port_format_err,
    i_seq_page_err, i_seq_reg_err, i_seq_wait_expired, i_seq_tardy, i_seq_irq, i_realtime_parity_err,
    i_bus_abort_err, i_bus_parity_err} = ev;
  assign {i_audio_start, i_twowire_start, i_ext_cmd_start, i_seq_task_start, i_vsync} = cl;
  assign {i_video_fifo_flow_err, i_video_addr_guard_err, i_audio_fifo_flow_err, i_seq_active, i_twowire_busy,
    i_ext_port_busy, i_shadow_load_active} = lv;
  // Primary and secondary bit per event, 0 where no secondary bit
  localparam int pb[21] = '{31, 30, 29, 27, 28, 25, 26, 21, 22, 23, 24, 23, 24, 18, 18, 16, 16, 12, 13, 14, 15};
  localparam int sb[21] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 26, 29, 25, 28, 22, 23, 21, 20, 0, 0, 0, 0};
  always #12.5 i_clk = ~i_clk;
  psil_top dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_bus_parity_err,
    .i_bus_abort_err, .i_realtime_parity_err, .i_vsync, .i_seq_wait, .i_seq_in_control, .i_seq_task_start,
    .i_seq_irq, .i_seq_tardy, .i_seq_wait_expired, .i_seq_reg_err, .i_seq_page_err, .i_seq_active,
    .i_shadow_load_active, .i_ext_port_busy, .i_ext_cmd_start, .i_ext_port_format_err, .i_ext_port_timeout,
    .i_twowire_busy, .i_twowire_start, .i_twowire_addr_err, .i_twowire_write_err, .i_audio_guard,
    .i_audio_start, .i_audio_fifo_flow_err, .i_video_addr_guard_err, .i_video_fifo_flow_err);
  task automatic chk(input psil_word_t got, input psil_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input psil_addr_t a, input psil_word_t d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input psil_addr_t a, input psil_word_t exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic finish_test;
    $display("samples_checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`PSIL_OFF_PSR, 32'h00040000);
    rd(`PSIL_OFF_SSR, 32'h00800000);
    rd(`PSIL_OFF_ISR, 32'h0);
    rd(12'h000, 32'h0);
    chk({31'h0, o_irq}, 32'h0);
    wr(`PSIL_OFF_IER, 32'hffffffff);
    rd(`PSIL_OFF_IER, 32'hfffffe00);
    wr(`PSIL_OFF_ISR, 32'hffffffff);
    rd(`PSIL_OFF_SSR, 32'h0);
    rd(`PSIL_OFF_PSR, 32'h0);
    rd(`PSIL_OFF_ISR, 32'h0);
    for (int i = 0; i < 21; i++) begin
      @(posedge i_clk);
      ev <= 21'h1 << i;
      @(posedge i_clk);
      ev <= 21'h0;
      rd(`PSIL_OFF_PSR, 32'h1 << pb[i]);
      rd(`PSIL_OFF_SSR, (sb[i] == 0) ? 32'h0 : 32'h1 << sb[i]);
      rd(`PSIL_OFF_ISR, 32'h1 << pb[i]);
      chk({31'h0, o_irq}, 32'h1);
      @(posedge i_clk);
      cl <= 9'h1ff;
      @(posedge i_clk);
      cl <= 9'h0;
      rd(`PSIL_OFF_PSR, (i < 2) ? 32'h1 << pb[i] : 32'h0);
      rd(`PSIL_OFF_ISR, 32'h1 << pb[i]);
      wr(`PSIL_OFF_ISR, 32'h1 << pb[i]);
      rd(`PSIL_OFF_ISR, 32'h0);
      rd(`PSIL_OFF_PSR, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
    end
    wr(`PSIL_OFF_IER, 32'h0);
    @(posedge i_clk);
    ev <= 21'h1;
    @(posedge i_clk);
    ev <= 21'h0;
    rd(`PSIL_OFF_PSR, 32'h80000000);
    rd(`PSIL_OFF_ISR, 32'h0);
    wr(`PSIL_OFF_IER, 32'h80000000);
    wr(`PSIL_OFF_PSR, 32'h0);
    rd(`PSIL_OFF_ISR, 32'h0);
    wr(`PSIL_OFF_PSR, 32'h80000000);
    rd(`PSIL_OFF_ISR, 32'h80000000);
    chk({31'h0, o_irq}, 32'h1);
    rd(`PSIL_OFF_PSR, 32'h80000000);
    wr(`PSIL_OFF_SSR, 32'hffffffff);
    rd(`PSIL_OFF_SSR, 32'h0);
    // Under sequencer control vsync must not end the parity window
    @(posedge i_clk);
    i_seq_in_control <= 1'b1;
    ev <= 21'h4;
    @(posedge i_clk);
    ev <= 21'h0;
    cl <= 9'h1;
    @(posedge i_clk);
    cl <= 9'h0;
    rd(`PSIL_OFF_PSR, 32'ha0000000);
    @(posedge i_clk);
    i_seq_wait <= 1'b1;
    @(posedge i_clk);
    i_seq_wait <= 1'b0;
    i_seq_in_control <= 1'b0;
    rd(`PSIL_OFF_PSR, 32'h80000000);
    // Write-one to flags alone clears the secondary detail
    @(posedge i_clk);
    ev <= 21'h00a400;
    @(posedge i_clk);
    ev <= 21'h0;
    rd(`PSIL_OFF_SSR, 32'h20600000);
    rd(`PSIL_OFF_PSR, 32'h81050000);
    wr(`PSIL_OFF_ISR, 32'h01050000);
    rd(`PSIL_OFF_SSR, 32'h0);
    rd(`PSIL_OFF_PSR, 32'h80000000);
    wr(`PSIL_OFF_ISR, 32'hffffffff);
    wr(`PSIL_OFF_IER, 32'hffffffff);
    @(posedge i_clk);
    lv <= 15'h7fff;
    rd(`PSIL_OFF_PSR, 32'h001a0e00);
    rd(`PSIL_OFF_SSR, 32'h09000000);
    rd(`PSIL_OFF_ISR, 32'h00000e00);
    @(posedge i_clk);
    lv <= 15'h0;
    rd(`PSIL_OFF_PSR, 32'h0);
    rd(`PSIL_OFF_ISR, 32'h001a0e00);
    chk({31'h0, o_irq}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
